// [ect_pkg.sv]
// Package of constants and carrier types for the buffered capture timer.
// Notes on behaviour
// - Main 16-bit up-counter advances through a 7-bit prescaler.
// - Eight channels; a channel captures when its select bit chooses capture.
// - Four channels hold one capture word; four add a 16-bit holding word.
// - Capture empty once read or latched; holding empty once read.
// - Valid pin edge stores the counter; without no-overwrite it replaces old value.
// - With no-overwrite set, a full plain capture register is not rewritten.
// - Latch mode copies capture to holding on modulus zero, zero write or force.
// - Latch mode without no-overwrite: captures and latches simply replace contents.
// - Buffered with no-overwrite: no event overwrites an unread capture or holding word.
// - Queue mode: a capture first pushes the old capture word into holding.
// - Queue mode: reading a holding word copies and clears its accumulator.
// - Four 8-bit edge accumulators, one per buffered channel, each with holding.
// - With saturation set, 8-bit accumulators stop at 255.
// - Each accumulator pair may run as one 16-bit accumulator.
// - Latch mode copies and clears accumulators on modulus zero, zero write or force.
// - A 16-bit modulus down-counter runs through its own 4-bit prescaler.
// - Modulus counter is a periodic time base; latching is repeating or single-shot.
// - Four selectable delay counters reject short pulses on capture inputs.
package ect_pkg;
	localparam logic [7:0] ADR_SELECT = 8'h00;
	localparam logic [7:0] ADR_PRESCALE = 8'h01;
	localparam logic [7:0] ADR_COUNTER = 8'h02;
	localparam logic [7:0] ADR_NOVW = 8'h03;
	localparam logic [7:0] ADR_MODCTL = 8'h04;
	localparam logic [7:0] ADR_MODCNT = 8'h05;
	localparam logic [7:0] ADR_SYSCTL = 8'h06;
	localparam logic [7:0] ADR_FLAGS = 8'h07;
	localparam logic [7:0] ADR_EDGE = 8'h08;
	localparam logic [7:0] ADR_DELAY = 8'h09;
	localparam logic [7:0] ADR_CAP_BASE = 8'h10;
	localparam logic [7:0] ADR_HOLD_BASE = 8'h18;
	localparam logic [7:0] ADR_ACC_BASE = 8'h1C;
	localparam logic [7:0] ADR_ACCH_BASE = 8'h20;
	localparam int MODCTL_LATCH_QUEUE_SELECT = 0;
	localparam int MODCTL_ENABLE = 1;
	localparam int MODCTL_SINGLE = 2;
	localparam int MODCTL_FORCE = 3;
	localparam int MODCTL_PRE_LSB = 4;
	localparam int SYS_SAT = 0;
	localparam int SYS_PAIR_LO = 1;
	localparam int SYS_PAIR_HI = 2;
	localparam int SYS_TEN = 3;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] ACC_MAX = 8'hFF;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} wb_req_type;
	typedef struct packed {
		logic [7:0] select;
		logic [6:0] prescale;
		logic [7:0] novw;
		logic [7:0] modctl;
		logic [15:0] modload;
		logic [3:0] sysctl;
		logic [15:0] edge_cfg;
		logic [7:0] delay_cfg;
	} cfg_type;
endpackage

// [buffered_capture_timer.sv]
// Enhanced capture timer core with a classic Wishbone register slave.
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module buffered_capture_timer import ect_pkg::*; (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [31:0] WB_DAT_IN,
	input wire logic [7:0] CAPTURE_PINS_IN,
	input wire logic [3:0] ACC_PINS_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	output logic [7:0] CAPTURE_FLAGS_OUT,
	output logic MODULUS_ZERO_OUT
);
	typedef struct packed {
		cfg_type cfg;
		logic [6:0] pre_cnt;
		logic [15:0] count;
		logic [3:0] mpre_cnt;
		logic [15:0] modcnt;
		logic mod_done;
		logic mod_zero;
		logic [7:0] pin_prev;
		logic [7:0] filt;
		logic [3:0][7:0] dly_cnt;
		logic [3:0] acc_prev;
		logic [7:0][15:0] cap;
		logic [7:0] cap_full;
		logic [3:0][15:0] hold;
		logic [3:0] hold_full;
		logic [3:0][7:0] acc;
		logic [3:0][7:0] acch;
		logic [7:0] flags;
		logic ack;
		logic [31:0] rdata;
	} state_type;

	state_type s_q;
	state_type s_d;

	always_comb begin
		logic access;
		logic wr;
		logic rd;
		logic [31:0] rd_v;
		logic main_tick;
		logic mod_tick;
		logic latch_ev;
		logic [7:0] valid_edge;
		logic [3:0] acc_edge;
		logic [3:0] acc_clr;
		logic [3:0] hold_rd;
		logic [7:0] cap_rd;
		logic [15:0] pair;
		s_d = s_q;
		pair = 16'h0000;
		valid_edge = 8'h00;
		acc_edge = 4'h0;
		access = WB_CYC_IN && WB_STB_IN && !s_q.ack;
		wr = access && WB_WE_IN && WB_SEL_IN[0];
		rd = access && !WB_WE_IN;
		rd_v = 32'h0000_0000;
		latch_ev = 1'b0;
		acc_clr = 4'h0;
		hold_rd = 4'h0;
		cap_rd = 8'h00;
		s_d.ack = access;
		s_d.mod_zero = 1'b0;
		s_d.cfg.modctl[MODCTL_FORCE] = 1'b0;
		// Main counter stops when the timer enable is clear, saving power.
		main_tick = 1'b0;
		if (s_q.cfg.sysctl[SYS_TEN]) begin
			if (s_q.pre_cnt >= s_q.cfg.prescale) begin
				s_d.pre_cnt = 7'h00;
				main_tick = 1'b1;
			end else begin
				s_d.pre_cnt = s_q.pre_cnt + 7'h01;
			end
		end
		if (main_tick) begin
			s_d.count = s_q.count + 16'h0001;
		end
		// Modulus counter with its own 4-bit prescaler.
		mod_tick = 1'b0;
		if (s_q.cfg.modctl[MODCTL_ENABLE] && !s_q.mod_done) begin
			if (s_q.mpre_cnt >= s_q.cfg.modctl[7:4]) begin
				s_d.mpre_cnt = 4'h0;
				mod_tick = 1'b1;
			end else begin
				s_d.mpre_cnt = s_q.mpre_cnt + 4'h1;
			end
		end
		if (mod_tick) begin
			if (s_q.modcnt == 16'h0001 || s_q.modcnt == 16'h0000) begin
				s_d.mod_zero = 1'b1;
				latch_ev = 1'b1;
				s_d.modcnt = s_q.cfg.modload;
				if (s_q.cfg.modctl[MODCTL_SINGLE]) begin
					s_d.mod_done = 1'b1;
				end
			end else begin
				s_d.modcnt = s_q.modcnt - 16'h0001;
			end
		end
		// Input qualification: a level must hold for the selected delay before it counts.
		for (int i = 0; i < 8; i++) begin
			if (CAPTURE_PINS_IN[i] == s_q.filt[i]) begin
				s_d.dly_cnt[i / 2] = 8'h00;
			end
			s_d.pin_prev[i] = s_q.filt[i];
		end
		for (int k = 0; k < 4; k++) begin
			logic [7:0] need;
			need = {4'h0, s_q.cfg.delay_cfg[2*k +: 2], 2'b00};
			if ((CAPTURE_PINS_IN[2*k] != s_q.filt[2*k]) || (CAPTURE_PINS_IN[2*k+1] != s_q.filt[2*k+1])) begin
				if (s_q.dly_cnt[k] >= need) begin
					s_d.filt[2*k +: 2] = CAPTURE_PINS_IN[2*k +: 2];
					s_d.dly_cnt[k] = 8'h00;
				end else begin
					s_d.dly_cnt[k] = s_q.dly_cnt[k] + 8'h01;
				end
			end else begin
				s_d.dly_cnt[k] = 8'h00;
			end
		end
		for (int i = 0; i < 8; i++) begin
			logic rise;
			logic fall;
			rise = s_q.filt[i] && !s_q.pin_prev[i];
			fall = !s_q.filt[i] && s_q.pin_prev[i];
			valid_edge[i] = !s_q.cfg.select[i] &&
				((rise && s_q.cfg.edge_cfg[2*i]) || (fall && s_q.cfg.edge_cfg[2*i+1]));
		end
		for (int k = 0; k < 4; k++) begin
			acc_edge[k] = ACC_PINS_IN[k] && !s_q.acc_prev[k];
			s_d.acc_prev[k] = ACC_PINS_IN[k];
		end
		// Register bus: decode, writes and side effects of reads.
		if (wr) begin
			case (WB_ADR_IN)
				ADR_SELECT: s_d.cfg.select = WB_DAT_IN[7:0];
				ADR_PRESCALE: s_d.cfg.prescale = WB_DAT_IN[6:0];
				ADR_NOVW: s_d.cfg.novw = WB_DAT_IN[7:0];
				ADR_MODCTL: begin
					s_d.cfg.modctl = WB_DAT_IN[7:0];
					s_d.cfg.modctl[MODCTL_FORCE] = 1'b0;
					s_d.mod_done = 1'b0;
					if (WB_DAT_IN[MODCTL_FORCE]) begin
						latch_ev = 1'b1;
					end
				end
				ADR_MODCNT: begin
					if (WB_SEL_IN[1]) begin
						s_d.cfg.modload = WB_DAT_IN[15:0];
						s_d.modcnt = WB_DAT_IN[15:0];
						s_d.mpre_cnt = 4'h0;
						s_d.mod_done = 1'b0;
						if (WB_DAT_IN[15:0] == 16'h0000) begin
							latch_ev = 1'b1;
						end
					end
				end
				ADR_SYSCTL: s_d.cfg.sysctl = WB_DAT_IN[3:0];
				ADR_FLAGS: s_d.flags = s_q.flags & ~WB_DAT_IN[7:0];
				ADR_EDGE: begin
					if (WB_SEL_IN[1]) begin
						s_d.cfg.edge_cfg = WB_DAT_IN[15:0];
					end
				end
				ADR_DELAY: s_d.cfg.delay_cfg = WB_DAT_IN[7:0];
				default: begin
				end
			endcase
		end
		if (rd) begin
			case (WB_ADR_IN)
				ADR_SELECT: rd_v = {24'h00_0000, s_q.cfg.select};
				ADR_PRESCALE: rd_v = {25'h000_0000, s_q.cfg.prescale};
				ADR_COUNTER: rd_v = {16'h0000, s_q.count};
				ADR_NOVW: rd_v = {24'h00_0000, s_q.cfg.novw};
				ADR_MODCTL: rd_v = {24'h00_0000, s_q.cfg.modctl};
				ADR_MODCNT: rd_v = {16'h0000, s_q.modcnt};
				ADR_SYSCTL: rd_v = {28'h000_0000, s_q.cfg.sysctl};
				ADR_FLAGS: rd_v = {16'h0000, s_q.cap_full, s_q.flags};
				ADR_EDGE: rd_v = {16'h0000, s_q.cfg.edge_cfg};
				ADR_DELAY: rd_v = {24'h00_0000, s_q.cfg.delay_cfg};
				default: begin
					for (int i = 0; i < 8; i++) begin
						if (WB_ADR_IN == ADR_CAP_BASE + 8'(i)) begin
							rd_v = {16'h0000, s_q.cap[i]};
							cap_rd[i] = 1'b1;
						end
					end
					for (int k = 0; k < 4; k++) begin
						if (WB_ADR_IN == ADR_HOLD_BASE + 8'(k)) begin
							rd_v = {16'h0000, s_q.hold[k]};
							hold_rd[k] = 1'b1;
						end
						if (WB_ADR_IN == ADR_ACC_BASE + 8'(k)) begin
							rd_v = {24'h00_0000, s_q.acc[k]};
						end
						if (WB_ADR_IN == ADR_ACCH_BASE + 8'(k)) begin
							rd_v = {24'h00_0000, s_q.acch[k]};
						end
					end
				end
			endcase
		end
		s_d.rdata = rd_v;
		for (int i = 0; i < 8; i++) begin
			if (cap_rd[i]) begin
				s_d.cap_full[i] = 1'b0;
			end
		end
		for (int k = 0; k < 4; k++) begin
			if (hold_rd[k]) begin
				s_d.hold_full[k] = 1'b0;
				if (!s_q.cfg.modctl[MODCTL_LATCH_QUEUE_SELECT]) begin
					s_d.acch[k] = s_q.acc[k];
					acc_clr[k] = 1'b1;
				end
			end
		end
		// In latch mode, latch events move buffered captures (channels 4..7) and accumulators to holding.
		if (latch_ev && s_q.cfg.modctl[MODCTL_LATCH_QUEUE_SELECT]) begin
			for (int k = 0; k < 4; k++) begin
				if (!s_q.cfg.novw[k+4] || !s_d.hold_full[k]) begin
					if (s_q.cap_full[k+4] || !s_q.cfg.novw[k+4]) begin
						s_d.hold[k] = s_q.cap[k+4];
						s_d.hold_full[k] = 1'b1;
						s_d.cap_full[k+4] = 1'b0;
					end
				end
				s_d.acch[k] = s_q.acc[k];
				acc_clr[k] = 1'b1;
			end
		end
		// Captures; a capture in the same cycle as a read of its register wins.
		for (int i = 0; i < 8; i++) begin
			if (valid_edge[i]) begin
				if (i < 4) begin
					if (!s_q.cfg.novw[i] || !s_d.cap_full[i]) begin
						s_d.cap[i] = s_q.count;
						s_d.cap_full[i] = 1'b1;
						s_d.flags[i] = 1'b1;
					end
				end else if (s_q.cfg.modctl[MODCTL_LATCH_QUEUE_SELECT]) begin
					if (!s_q.cfg.novw[i] || !s_d.cap_full[i]) begin
						s_d.cap[i] = s_q.count;
						s_d.cap_full[i] = 1'b1;
						s_d.flags[i] = 1'b1;
					end
				end else begin
					if (!s_q.cfg.novw[i]) begin
						s_d.hold[i-4] = s_d.cap[i];
						s_d.hold_full[i-4] = s_d.cap_full[i];
						s_d.cap[i] = s_q.count;
						s_d.cap_full[i] = 1'b1;
						s_d.flags[i] = 1'b1;
					end else if (!s_d.cap_full[i] || !s_d.hold_full[i-4]) begin
						if (s_d.cap_full[i]) begin
							s_d.hold[i-4] = s_d.cap[i];
							s_d.hold_full[i-4] = 1'b1;
						end
						s_d.cap[i] = s_q.count;
						s_d.cap_full[i] = 1'b1;
						s_d.flags[i] = 1'b1;
					end
				end
			end
		end
		// Accumulators; a paired pair counts as one 16-bit value, low half first.
		for (int k = 0; k < 4; k++) begin
			if (acc_clr[k]) begin
				s_d.acc[k] = 8'h00;
			end
		end
		for (int p = 0; p < 2; p++) begin
			if (s_q.cfg.sysctl[SYS_PAIR_LO + p]) begin
				pair = {s_q.acc[2*p+1], s_q.acc[2*p]};
				if (acc_edge[2*p] && !acc_clr[2*p]) begin
					pair = pair + 16'h0001;
					s_d.acc[2*p] = pair[7:0];
					s_d.acc[2*p+1] = acc_clr[2*p+1] ? 8'h00 : pair[15:8];
				end
			end else begin
				for (int j = 0; j < 2; j++) begin
					if (acc_edge[2*p+j] && !acc_clr[2*p+j]) begin
						if (!(s_q.cfg.sysctl[SYS_SAT] && s_q.acc[2*p+j] == ACC_MAX)) begin
							s_d.acc[2*p+j] = s_q.acc[2*p+j] + 8'h01;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		WB_DAT_OUT = s_q.rdata;
		WB_ACK_OUT = s_q.ack;
		CAPTURE_FLAGS_OUT = s_q.flags;
		MODULUS_ZERO_OUT = s_q.mod_zero;
	end
endmodule

// [bct_chk.sv]
// Checker of bus timing, flag and pulse behaviour at the timer ports.
`timescale 1ns/10ps
module bct_chk import ect_pkg::*; (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [7:0] CAPTURE_PINS_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	input wire logic [7:0] CAPTURE_FLAGS_OUT,
	input wire logic MODULUS_ZERO_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic [7:0] pins_q;
	logic [4:0] quiet_q;
	// Cycles since the pins last moved; a flag may only rise shortly after a pin change.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pins_q <= 8'h00;
			quiet_q <= 5'h1F;
		end else begin
			pins_q <= CAPTURE_PINS_IN;
			quiet_q <= (CAPTURE_PINS_IN != pins_q) ? 5'h00 : (quiet_q == 5'h1F) ? quiet_q : quiet_q + 5'h01;
		end
	end
	property p_ack_next;
		WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
	property p_ack_pulse;
		WB_ACK_OUT |=> !WB_ACK_OUT;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause;
		WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_unmapped;
		WB_ACK_OUT && $past(!WB_WE_IN && WB_ADR_IN >= 8'h24) |-> WB_DAT_OUT == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_flag_clear;
		|($past(CAPTURE_FLAGS_OUT) & ~CAPTURE_FLAGS_OUT) |-> WB_ACK_OUT && $past(WB_WE_IN && WB_ADR_IN == ADR_FLAGS);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag fell without clear write");
	property p_flag_cause;
		|(CAPTURE_FLAGS_OUT & ~$past(CAPTURE_FLAGS_OUT)) |-> quiet_q <= 5'h14;
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag rose without pin edge");
	property p_reset_quiet;
		$rose(RST_N_IN) |-> !WB_ACK_OUT && CAPTURE_FLAGS_OUT == 8'h00 && !MODULUS_ZERO_OUT;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not clear after reset");
	property p_mz_pulse;
		MODULUS_ZERO_OUT |=> !MODULUS_ZERO_OUT;
	endproperty
	a_mz_pulse: assert property (p_mz_pulse) else $error("modulus zero longer than one cycle");
	c_ack: cover property (WB_ACK_OUT && !WB_WE_IN);
	c_flag: cover property (|CAPTURE_FLAGS_OUT);
	c_mz: cover property (MODULUS_ZERO_OUT);
endmodule
bind buffered_capture_timer bct_chk bct_chk_inst (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .CAPTURE_PINS_IN(CAPTURE_PINS_IN),
	.WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .CAPTURE_FLAGS_OUT(CAPTURE_FLAGS_OUT),
	.MODULUS_ZERO_OUT(MODULUS_ZERO_OUT));

// [pin_src.sv]
// Model of the capture and accumulator pin sources.
`timescale 1ns/10ps
module pin_src (
	input wire logic clk_in,
	output logic [7:0] cap_out,
	output logic [3:0] acc_out
);
	initial begin
		cap_out = 8'h00;
		acc_out = 4'h0;
	end
	// Pulses stay high eight cycles, so that delay settings 0 and 1 accept them.
	task automatic pulse(input logic [7:0] m);
		@(posedge clk_in) cap_out <= cap_out | m;
		repeat (8) @(posedge clk_in);
		cap_out <= cap_out & ~m;
		repeat (8) @(posedge clk_in);
	endtask
	task automatic edges(input logic [3:0] m, input int n);
		repeat (n) begin
			@(posedge clk_in) acc_out <= m;
			@(posedge clk_in) acc_out <= 4'h0;
		end
	endtask
endmodule

// [tb.sv]
// Self-checking bench for the buffered capture timer.
`timescale 1ns/10ps
module tb import ect_pkg::*; ();
	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] wd;
		logic [31:0] rd;
	} row_type;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	wb_req_type req = '0;
	logic [3:0] bsel = 4'hF;
	logic [31:0] rdat, rd, c, c2;
	logic ack, mz;
	logic [7:0] flags, cap;
	logic [3:0] acc;
	int err_count = 0;
	int num_checks = 0;
	row_type rows [14] = '{'{ADR_SELECT, 32'h0000_01A5, 32'h0000_00A5}, '{ADR_PRESCALE, 32'h0000_00FF, 32'h0000_007F},
		'{ADR_NOVW, 32'h0000_005A, 32'h0000_005A}, '{ADR_MODCTL, 32'h0000_00FC, 32'h0000_00F4},
		'{ADR_SYSCTL, 32'h0000_00F7, 32'h0000_0007}, '{ADR_DELAY, 32'h0000_01E4, 32'h0000_00E4},
		'{ADR_EDGE, 32'h0001_5555, 32'h0000_5555}, '{8'h30, 32'h0000_FFFF, 32'h0000_0000},
		'{ADR_SELECT, 32'h0000_0002, 32'h0000_0002}, '{ADR_NOVW, 32'h0000_0000, 32'h0000_0000},
		'{ADR_DELAY, 32'h0000_0000, 32'h0000_0000}, '{ADR_SYSCTL, 32'h0000_0008, 32'h0000_0008},
		'{ADR_PRESCALE, 32'h0000_0003, 32'h0000_0003}, '{ADR_MODCTL, 32'h0000_0000, 32'h0000_0000}};
	initial forever #10 clk = ~clk;
	buffered_capture_timer buffered_capture_timer_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(req.cyc),
		.WB_STB_IN(req.stb), .WB_WE_IN(req.we), .WB_SEL_IN(req.sel), .WB_ADR_IN(req.adr), .WB_DAT_IN(req.dat),
		.CAPTURE_PINS_IN(cap), .ACC_PINS_IN(acc), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
		.CAPTURE_FLAGS_OUT(flags), .MODULUS_ZERO_OUT(mz));
	pin_src pin_src_inst (.clk_in(clk), .cap_out(cap), .acc_out(acc));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// The counter may tick once between reading it and the capture landing.
	task automatic near(input string n, input logic [31:0] e, input logic [31:0] g);
		chk(n, e, (g === e + 32'h1) ? e : g);
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		req <= '{1'b1, 1'b1, we, bsel, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		req <= '0;
		if (ack !== 1'b1) begin
			chk("ack", 32'h1, {31'h0, ack});
			end_sim();
		end
		@(posedge clk);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, ADR_COUNTER, 32'h0, rd);
		chk("counter reset", 32'h0000_0000, rd);
		for (int i = 0; i < 14; i++) begin
			wb(1'b1, rows[i].adr, rows[i].wd, rd);
			wb(1'b0, rows[i].adr, 32'h0, rd);
			chk("register", rows[i].rd, rd);
		end
		// A write that leaves out the upper byte lane must not touch a 16-bit register.
		bsel = 4'h1;
		wb(1'b1, ADR_EDGE, 32'h0000_0000, rd);
		bsel = 4'hF;
		wb(1'b0, ADR_EDGE, 32'h0, rd);
		chk("edge narrow write", 32'h0000_5555, rd);
		wb(1'b0, ADR_COUNTER, 32'h0, c);
		repeat (37) @(posedge clk);
		wb(1'b0, ADR_COUNTER, 32'h0, rd);
		chk("counter rate", c + 32'h0000_000A, rd);
		wb(1'b1, ADR_PRESCALE, 32'h0000_007F, rd);
		wb(1'b0, ADR_COUNTER, 32'h0, c);
		pin_src_inst.pulse(8'hCF);
		chk("flag pins", 32'h0000_00CD, {24'h0, flags});
		wb(1'b1, ADR_FLAGS, 32'h0000_00FF, rd);
		chk("flag clear", 32'h0000_0000, {24'h0, flags});
		wb(1'b1, ADR_NOVW, 32'h0000_0001, rd);
		repeat (300) @(posedge clk);
		pin_src_inst.pulse(8'h01);
		wb(1'b0, ADR_CAP_BASE, 32'h0, rd);
		near("cap kept", c, rd);
		wb(1'b0, ADR_COUNTER, 32'h0, c);
		pin_src_inst.pulse(8'h01);
		wb(1'b0, ADR_CAP_BASE, 32'h0, rd);
		near("cap after empty", c, rd);
		wb(1'b1, ADR_NOVW, 32'h0000_0000, rd);
		wb(1'b0, ADR_COUNTER, 32'h0, c);
		pin_src_inst.pulse(8'h10);
		repeat (300) @(posedge clk);
		wb(1'b0, ADR_COUNTER, 32'h0, c2);
		pin_src_inst.pulse(8'h10);
		pin_src_inst.edges(4'h1, 3);
		wb(1'b0, ADR_HOLD_BASE, 32'h0, rd);
		near("queue hold", c, rd);
		wb(1'b0, ADR_CAP_BASE + 8'h04, 32'h0, rd);
		near("queue cap", c2, rd);
		wb(1'b0, ADR_ACCH_BASE, 32'h0, rd);
		chk("acc hold queue", 32'h0000_0003, rd);
		wb(1'b0, ADR_ACC_BASE, 32'h0, rd);
		chk("acc cleared queue", 32'h0000_0000, rd);
		wb(1'b1, ADR_SYSCTL, 32'h0000_0009, rd);
		wb(1'b1, ADR_MODCTL, 32'h0000_0001, rd);
		wb(1'b0, ADR_COUNTER, 32'h0, c);
		pin_src_inst.pulse(8'h20);
		pin_src_inst.edges(4'h2, 260);
		wb(1'b0, ADR_ACC_BASE + 8'h01, 32'h0, rd);
		chk("acc saturate", 32'h0000_00FF, rd);
		wb(1'b1, ADR_MODCTL, 32'h0000_0009, rd);
		wb(1'b0, ADR_HOLD_BASE + 8'h01, 32'h0, rd);
		near("latch hold", c, rd);
		wb(1'b0, ADR_ACCH_BASE + 8'h01, 32'h0, rd);
		chk("acc hold latch", 32'h0000_00FF, rd);
		wb(1'b0, ADR_ACC_BASE + 8'h01, 32'h0, rd);
		chk("acc cleared latch", 32'h0000_0000, rd);
		// Paired counters run on the lower input only and are not held at the 8-bit ceiling.
		wb(1'b1, ADR_SYSCTL, 32'h0000_000D, rd);
		pin_src_inst.edges(4'hC, 260);
		wb(1'b0, ADR_ACC_BASE + 8'h02, 32'h0, rd);
		chk("pair low", 32'h0000_0004, rd);
		wb(1'b0, ADR_ACC_BASE + 8'h03, 32'h0, rd);
		chk("pair high", 32'h0000_0001, rd);
		wb(1'b1, ADR_MODCNT, 32'h0000_0003, rd);
		wb(1'b1, ADR_MODCTL, 32'h0000_0003, rd);
		for (int k = 0; k < 2; k++) begin
			for (int n = 0; n < 100 && mz !== 1'b1; n++) @(posedge clk);
			chk("modulus zero", 32'h1, {31'h0, mz});
			if (mz !== 1'b1)
				end_sim();
			@(posedge clk);
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, ADR_COUNTER, 32'h0, rd);
		chk("flags after reset", 32'h0000_0000, {24'h0, flags});
		chk("counter after reset", 32'h0000_0000, rd);
		end_sim();
	end
endmodule
